// [hdl/phb_regs.svh]
`ifndef PHB_REGS_SVH
`define PHB_REGS_SVH

`define PHB_NUM_EP 2
`define PHB_NUM_IRQ 224
`define PHB_INTX_BASE_ID 200
`define PHB_SERR_ID 207
`define PHB_IOMMU_IRQ_LO 103
`define PHB_IOMMU_IRQ_HI 111
`define PHB_IOMMU_BASE 32'h2B40_0000
`define PHB_IOMMU_LAST 32'h2B4F_FFFF
`define PHB_IOMMU_SELF_ID 17'h1_0000
`define PHB_INT_PIN_VAL 8'h01
`define PHB_EP0_DEV_RST 5'h00
`define PHB_EP1_DEV_RST 5'h02
`define PHB_BUS_RST 8'h00
`define PHB_MSI_WIN_BASE 32'h2F02_0000
`define PHB_MSI_WIN_MASK 32'hFFFF_0000

`endif

// [hdl/phb_pkg.sv]
package phb_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] data;
    } phb_bus_s;
    typedef struct packed {
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
    } phb_rid_s;
    typedef struct packed {
        logic msix_en;
        logic cfg_region_bar_wide;
        logic vector_table_bar_wide;
        logic pending_array_bar_wide;
    } phb_epcfg_s;
    typedef enum logic [2:0] {
        PHB_ROUTE_IDLE = 3'b001,
        PHB_ROUTE_LOCAL = 3'b010,
        PHB_ROUTE_FWD = 3'b100
    } phb_route_e;
endpackage

// [hdl/phb_intx_swizzle.sv]
`timescale 1ns/1ns
`default_nettype none
`include "phb_regs.svh"
module phb_intx_swizzle
    import phb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic [3:0] endpoint_pin_index_in,
    input wire logic [4:0] dev_in,
    output logic [3:0] swizzled_line_index_out
);
    // sync: pins come from outside the clock domain
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic [3:0] rot_w;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
        end else begin
            meta_r <= endpoint_pin_index_in;
            sync_r <= meta_r;
        end
    end
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_rot
            wire [1:0] src_w = 2'(g) - dev_in[1:0];
            assign rot_w[g] = sync_r[src_w];
        end
    endgenerate
    assign swizzled_line_index_out = rot_w;
endmodule
`default_nettype wire

// [hdl/phb_top.sv]
// Function
// - line = (device + pin) modulo four
// - intx on ids 200-203, serr on 207
// - interrupt pin register reads fixed one
// - stream id equals 16-bit requester id
// - msi device id equals requester id
// - iommu self id default 0x10000, configurable
// - msi payload rewritten with originator id
// - msi-x capability only when enabled
// - three bars, each 32 or 64 wide
// - bus 0-0xFF, device 0-0x1F configurable
// - reset devices 0 and 2, bus 0
// - iommu interrupts on ids 103-111
// - iommu registers at 0x2B400000-0x2B4FFFFF
// - iommu event output to clusters
// - endpoint dma passes through iommu
// - unclaimed slave traffic forwarded unchanged
// - 224 interrupt lines to controller
// - reset returns all state to initial
// - no ras error recording provided
`timescale 1ns/1ns
`default_nettype none
`include "phb_regs.svh"
module phb_top
    import phb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire phb_bus_s slv_req_in,
    output phb_bus_s fwd_req_out,
    output logic iommu_sel_out,
    input wire logic [7:0] ep0_bus_in,
    input wire logic [4:0] ep0_dev_in,
    input wire logic [7:0] ep1_bus_in,
    input wire logic [4:0] ep1_dev_in,
    input wire logic cfg_load_in,
    input wire phb_epcfg_s ep0_cfg_in,
    input wire phb_epcfg_s ep1_cfg_in,
    input wire logic [16:0] iommu_self_msg_id_in,
    input wire logic iommu_self_id_load_in,
    input wire logic [3:0] ep0_pins_in,
    input wire logic [3:0] ep1_pins_in,
    input wire logic [1:0] serr_in,
    input wire logic [8:0] iommu_irq_in,
    input wire logic iommu_event_in,
    input wire phb_bus_s ep0_dma_in,
    input wire phb_bus_s ep1_dma_in,
    input wire logic dma_sel_in,
    input wire logic [31:0] iommu_xlat_addr_in,
    output phb_bus_s dma_out,
    output logic [15:0] stream_id_out,
    output logic [16:0] msi_dev_id_out,
    output logic [7:0] ep0_int_pin_out,
    output logic [7:0] ep1_int_pin_out,
    output phb_epcfg_s ep0_cfg_out,
    output phb_epcfg_s ep1_cfg_out,
    output phb_rid_s ep0_rid_out,
    output phb_rid_s ep1_rid_out,
    output logic [16:0] iommu_self_msg_id_out,
    output logic cluster_event_out,
    output logic [223:0] irq_lines_out
);
    phb_rid_s rid0_r;
    phb_rid_s rid1_r;
    phb_epcfg_s cfg0_r;
    phb_epcfg_s cfg1_r;
    logic [16:0] self_id_r;
    phb_bus_s fwd_r;
    logic sel_r;
    phb_bus_s dma_r;
    logic [15:0] sid_r;
    logic [16:0] msi_id_r;
    logic [3:0] line0_w;
    logic [3:0] line1_w;
    logic [3:0] intx_w;
    logic [1:0] serr_meta_r;
    logic [1:0] serr_sync_r;
    logic [8:0] mmu_meta_r;
    logic [8:0] mmu_sync_r;
    logic ev_meta_r;
    logic ev_sync_r;
    logic [223:0] irq_r;
    logic [223:0] irq_nxt;

    phb_intx_swizzle u_swz0 (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .endpoint_pin_index_in(ep0_pins_in),
        .dev_in(rid0_r.dev),
        .swizzled_line_index_out(line0_w)
    );
    phb_intx_swizzle u_swz1 (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .endpoint_pin_index_in(ep1_pins_in),
        .dev_in(rid1_r.dev),
        .swizzled_line_index_out(line1_w)
    );
    assign intx_w = line0_w | line1_w;

    // reset defaults dev 0 and 2
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rid0_r <= '{bus: `PHB_BUS_RST, dev: `PHB_EP0_DEV_RST, func: 3'h0};
            rid1_r <= '{bus: `PHB_BUS_RST, dev: `PHB_EP1_DEV_RST, func: 3'h0};
            cfg0_r <= '0;
            cfg1_r <= '0;
        end else if (cfg_load_in) begin
            rid0_r <= '{bus: ep0_bus_in, dev: ep0_dev_in, func: 3'h0};
            rid1_r <= '{bus: ep1_bus_in, dev: ep1_dev_in, func: 3'h0};
            cfg0_r <= ep0_cfg_in;
            cfg1_r <= ep1_cfg_in;
        end
    end
    assign ep0_rid_out = rid0_r;
    assign ep1_rid_out = rid1_r;
    assign ep0_cfg_out = cfg0_r;
    assign ep1_cfg_out = cfg1_r;
    assign ep0_int_pin_out = `PHB_INT_PIN_VAL;
    assign ep1_int_pin_out = `PHB_INT_PIN_VAL;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            self_id_r <= `PHB_IOMMU_SELF_ID;
        end else if (iommu_self_id_load_in) begin
            self_id_r <= iommu_self_msg_id_in;
        end
    end
    // 17 bits so self id clears 16-bit range
    assign iommu_self_msg_id_out = self_id_r;

    wire claim_w = slv_req_in.valid && (slv_req_in.addr >= `PHB_IOMMU_BASE)
        && (slv_req_in.addr <= `PHB_IOMMU_LAST);
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fwd_r <= '0;
            sel_r <= 1'b0;
        end else begin
            fwd_r <= claim_w ? '0 : slv_req_in;
            sel_r <= claim_w;
        end
    end
    assign fwd_req_out = fwd_r;
    assign iommu_sel_out = sel_r;

    // dma arbitration into the iommu path
    wire phb_bus_s dma_w = dma_sel_in ? ep1_dma_in : ep0_dma_in;
    wire phb_rid_s rid_w = dma_sel_in ? rid1_r : rid0_r;
    wire is_msi_w = dma_w.valid && dma_w.write
        && ((dma_w.addr & `PHB_MSI_WIN_MASK) == `PHB_MSI_WIN_BASE);
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dma_r <= '0;
            sid_r <= 16'h0000;
            msi_id_r <= 17'h0_0000;
        end else begin
            dma_r <= dma_w;
            sid_r <= rid_w;
            msi_id_r <= {1'b0, rid_w};
            if (dma_w.valid) begin
                dma_r.addr <= iommu_xlat_addr_in;
            end
            if (is_msi_w) begin
                dma_r.data <= {16'h0000, rid_w};
            end
        end
    end
    assign dma_out = dma_r;
    assign stream_id_out = sid_r;
    assign msi_dev_id_out = msi_id_r;

    // synchronise async interrupt sources
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            serr_meta_r <= 2'h0;
            serr_sync_r <= 2'h0;
            mmu_meta_r <= 9'h000;
            mmu_sync_r <= 9'h000;
            ev_meta_r <= 1'b0;
            ev_sync_r <= 1'b0;
        end else begin
            serr_meta_r <= serr_in;
            serr_sync_r <= serr_meta_r;
            mmu_meta_r <= iommu_irq_in;
            mmu_sync_r <= mmu_meta_r;
            ev_meta_r <= iommu_event_in;
            ev_sync_r <= ev_meta_r;
        end
    end
    assign cluster_event_out = ev_sync_r;

    always_comb begin
        irq_nxt = '0;
        irq_nxt[`PHB_INTX_BASE_ID +: 4] = intx_w;
        irq_nxt[`PHB_SERR_ID] = |serr_sync_r;
        irq_nxt[`PHB_IOMMU_IRQ_HI:`PHB_IOMMU_IRQ_LO] = mmu_sync_r;
    end
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_r <= '0;
        end else begin
            irq_r <= irq_nxt;
        end
    end
    assign irq_lines_out = irq_r;

    a_intx_or: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        irq_r[203:200] == $past(intx_w))
        else $error("intx line not or of pins");
    a_serr_line: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        irq_r[207] == $past(|serr_sync_r))
        else $error("serr id wrong");
    a_pin_fixed: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        ep0_int_pin_out == 8'h01 && ep1_int_pin_out == 8'h01)
        else $error("interrupt pin not one");
    a_sid_rid: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        dma_w.valid |=> stream_id_out == $past(rid_w))
        else $error("stream id mismatch");
    a_msi_rewrite: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        is_msi_w |=> dma_out.data[15:0] == $past(rid_w))
        else $error("msi payload not rewritten");
    a_fwd_claim: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (slv_req_in.valid && !claim_w) |=> fwd_req_out == $past(slv_req_in))
        else $error("unclaimed not forwarded");
    a_win_claim: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (slv_req_in.valid && slv_req_in.addr[31:20] == 12'h2B4) |=> iommu_sel_out && !fwd_req_out.valid)
        else $error("iommu window not claimed");
    a_mmu_irq: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        irq_r[111:103] == $past(mmu_sync_r) && irq_r[102:0] == '0)
        else $error("iommu irq lines wrong");
    a_event_lat: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        $rose(iommu_event_in) ##1 iommu_event_in |=> cluster_event_out)
        else $error("event not passed");
    a_self_id: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        iommu_self_id_load_in |=> iommu_self_msg_id_out == $past(iommu_self_msg_id_in))
        else $error("self id not loaded");

    // settle count: sync stages still hold reset values at first
    // so latency checks wait until real pin history exists
    logic [1:0] up_r;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end

    // reset and numbering
    a_rst_rid: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (up_r == 2'h0) |-> ep0_rid_out.bus == `PHB_BUS_RST && ep0_rid_out.dev == `PHB_EP0_DEV_RST
        && ep1_rid_out.bus == `PHB_BUS_RST && ep1_rid_out.dev == `PHB_EP1_DEV_RST)
        else $error("reset numbering wrong");
    a_rst_state: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (up_r == 2'h0) |-> irq_lines_out == '0 && dma_out == '0 && fwd_req_out == '0
        && !iommu_sel_out && iommu_self_msg_id_out == `PHB_IOMMU_SELF_ID)
        else $error("state not initial after reset");
    a_rid_load: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        cfg_load_in |=> ep0_rid_out == {$past(ep0_bus_in), $past(ep0_dev_in), 3'h0}
        && ep1_rid_out == {$past(ep1_bus_in), $past(ep1_dev_in), 3'h0})
        else $error("numbering not loaded");
    a_rid_hold: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !cfg_load_in |=> $stable(ep0_rid_out) && $stable(ep1_rid_out))
        else $error("numbering changed without load");
    a_cfg_load: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        cfg_load_in |=> ep0_cfg_out == $past(ep0_cfg_in)
        && ep1_cfg_out == $past(ep1_cfg_in))
        else $error("endpoint options not loaded");
    a_bar_hold: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !cfg_load_in |=> $stable(ep0_cfg_out) && $stable(ep1_cfg_out))
        else $error("bar widths changed without load");
    a_self_hold: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !iommu_self_id_load_in |=> $stable(iommu_self_msg_id_out))
        else $error("self id changed without load");

    // slave and dma paths
    a_fwd_idle: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !slv_req_in.valid |=> !iommu_sel_out && !fwd_req_out.valid)
        else $error("idle slave cycle not idle");
    a_sel_only_win: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        iommu_sel_out |-> $past(slv_req_in.valid)
        && $past(slv_req_in.addr[31:20]) == 12'h2B4)
        else $error("iommu selected outside window");
    a_fwd_sel_excl: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        iommu_sel_out |-> fwd_req_out == '0)
        else $error("claimed request forwarded");
    a_msi_id_rid: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        dma_w.valid |=> msi_dev_id_out == {1'b0, $past(rid_w)})
        else $error("msi device id mismatch");
    a_sid_msi: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        stream_id_out == msi_dev_id_out[15:0] && !msi_dev_id_out[16])
        else $error("stream id and device id differ");
    a_dma_addr: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        dma_w.valid |=> dma_out.valid && dma_out.addr == $past(iommu_xlat_addr_in))
        else $error("dma not translated");
    a_dma_idle: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !dma_w.valid |=> !dma_out.valid)
        else $error("dma valid without request");
    a_dma_plain: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (dma_w.valid && !is_msi_w) |=> dma_out.data == $past(dma_w.data))
        else $error("plain dma data altered");

    // interrupt timing
    a_irq_unused: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        irq_r[223:208] == '0 && irq_r[206:204] == '0 && irq_r[199:112] == '0)
        else $error("unassigned interrupt line active");
    a_ep0_pin0: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (up_r == 2'h3) |-> line0_w[rid0_r.dev[1:0]] == $past(ep0_pins_in[0], 2))
        else $error("endpoint zero first pin misrouted");
    a_ep1_pin0: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (up_r == 2'h3) |-> line1_w[rid1_r.dev[1:0]] == $past(ep1_pins_in[0], 2))
        else $error("endpoint one first pin misrouted");
    a_serr_lat: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (up_r == 2'h3) |-> irq_r[207] == $past(|serr_in, 3))
        else $error("serr line latency wrong");
    a_mmu_lat: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (up_r == 2'h3) |-> irq_r[111:103] == $past(iommu_irq_in, 3))
        else $error("iommu irq latency wrong");
    a_event_delay: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (up_r == 2'h3) |-> cluster_event_out == $past(iommu_event_in, 2))
        else $error("event latency wrong");
    a_event_fall: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        $fell(iommu_event_in) ##1 !iommu_event_in |=> !cluster_event_out)
        else $error("event not released");
endmodule
`default_nettype wire

// [sim/phb_ep_model.sv]
`timescale 1ns/1ns
`default_nettype none
module phb_ep_model
    import phb_pkg::*;
(
    input wire logic [1:0] pin_sel_in,
    input wire logic pin_on_in,
    input wire logic go_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] data_in,
    output logic [3:0] pins_out,
    output phb_bus_s dma_out
);
    // any pin may be steered so every swizzle lane gets exercised
    assign pins_out = pin_on_in ? 4'(4'h1 << pin_sel_in) : 4'h0;
    // idle bus shows inverted lines so a stale value never passes
    assign dma_out = go_in ? phb_bus_s'{1'b1, 1'b1, addr_in, data_in}
        : phb_bus_s'{1'b0, 1'b0, ~addr_in, ~data_in};
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "phb_regs.svh"
module testbench
    import phb_pkg::*;
;
    logic clk = 0, rstn = 0, sel, ld, idld, ev, dsel, cev, po0, po1, g0, g1;
    phb_bus_s slv, fwd, dm0, dm1, dmo;
    logic [7:0] b0, b1, ip0, ip1;
    logic [4:0] d0, d1;
    phb_epcfg_s c0i, c1i, c0o, c1o;
    logic [16:0] idi, ido, mid;
    logic [3:0] p0, p1;
    logic [1:0] serr, ps0, ps1;
    logic [8:0] iirq;
    logic [31:0] xl, a, dt;
    logic [15:0] sid, rid;
    phb_rid_s r0, r1;
    logic [223:0] irq;
    integer bad_count = 0, num_checks = 0, seed = 90977, i, k, ln;
    logic [31:0] corner [4] = '{32'h2B40_0000, 32'h2B4F_FFFF, 32'h2B3F_FFFF, 32'h2B50_0000};
    phb_top DUT (.core_clk_in(clk), .resetn_in(rstn), .slv_req_in(slv), .fwd_req_out(fwd),
        .iommu_sel_out(sel), .ep0_bus_in(b0), .ep0_dev_in(d0), .ep1_bus_in(b1), .ep1_dev_in(d1),
        .cfg_load_in(ld), .ep0_cfg_in(c0i), .ep1_cfg_in(c1i), .iommu_self_msg_id_in(idi),
        .iommu_self_id_load_in(idld), .ep0_pins_in(p0), .ep1_pins_in(p1), .serr_in(serr),
        .iommu_irq_in(iirq), .iommu_event_in(ev), .ep0_dma_in(dm0), .ep1_dma_in(dm1), .dma_sel_in(dsel),
        .iommu_xlat_addr_in(xl), .dma_out(dmo), .stream_id_out(sid), .msi_dev_id_out(mid),
        .ep0_int_pin_out(ip0), .ep1_int_pin_out(ip1), .ep0_cfg_out(c0o), .ep1_cfg_out(c1o),
        .ep0_rid_out(r0), .ep1_rid_out(r1), .iommu_self_msg_id_out(ido), .cluster_event_out(cev),
        .irq_lines_out(irq));
    phb_ep_model EP0 (.pin_sel_in(ps0), .pin_on_in(po0), .go_in(g0), .addr_in(a), .data_in(dt),
        .pins_out(p0), .dma_out(dm0));
    phb_ep_model EP1 (.pin_sel_in(ps1), .pin_on_in(po1), .go_in(g1), .addr_in(a), .data_in(dt),
        .pins_out(p1), .dma_out(dm1));
    always #4 clk = ~clk;
    task chk(input string nm, input logic [127:0] s, input logic [127:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic int line_of(input logic [4:0] d, input int p);
        return 200 + ((int'(d) + p) % 4);
    endfunction
    initial begin
        #200000;
        bad_count++;
        print_verdict;
    end
    initial begin
        {slv, ld, idld, ev, dsel, po0, po1, g0, g1, b0, b1, d0, d1, c0i, c1i, idi, serr, iirq, xl, a, dt} = '0;
        {ps0, ps1} = '0;
        cyc(3);
        rstn = 1;
        cyc(1);
        for (k = 0; k < 2; k++) begin
            chk("rid0", r0, 16'h0000);
            chk("rid1", r1, 16'h0010);
            chk("self_id", ido, 17'h1_0000);
            chk("self_id_msb", ido[16], 1'b1);
            chk("irq_idle", irq, 224'h0);
            chk("int_pin", {ip0, ip1}, 16'h0101);
            if (k == 0) begin
                d0 = 5'h1F;
                b0 = 8'hFF;
                ld = 1;
                idi = 17'h0_1234;
                idld = 1;
                cyc(1);
                {ld, idld} = '0;
                rstn = 0;
                cyc(1);
                rstn = 1;
                cyc(1);
            end
        end
        $display("test reset done");
        for (i = 0; i < 24; i++) begin
            a = (i < 4) ? corner[i] : $random(seed);
            slv = '{1'b1, a[0], a, 32'($random(seed))};
            cyc(1);
            k = (a >= `PHB_IOMMU_BASE && a <= `PHB_IOMMU_LAST);
            chk("iommu_sel", sel, k);
            chk("fwd", fwd, k ? '0 : slv);
        end
        slv = '0;
        $display("test forward done");
        for (i = 0; i < 6; i++) begin
            d0 = (i == 0) ? 5'h1F : 5'($random(seed));
            d1 = d0 + 5'h1;
            b0 = $random(seed);
            b1 = $random(seed);
            ld = 1;
            cyc(1);
            ld = 0;
            cyc(1);
            chk("rid0", r0, {b0, d0, 3'h0});
            chk("rid1", r1, {b1, d1, 3'h0});
            for (k = 0; k < 4; k++) begin
                ln = line_of(d0, k);
                ps0 = 2'(k);
                ps1 = 2'(k + 3);
                po0 = 1;
                cyc(4);
                chk("line", irq[ln], 1'b1);
                chk("lines", irq[203:200], 4'(4'h1 << (ln - 200)));
                po1 = 1;
                cyc(4);
                chk("both", irq[203:200], 4'(4'h1 << (ln - 200)));
                po0 = 0;
                cyc(4);
                chk("shared", irq[ln], 1'b1);
                po1 = 0;
                cyc(4);
                chk("released", irq[203:200], 4'h0);
            end
        end
        $display("test swizzle done");
        for (i = 0; i < 10; i++) begin
            iirq = (i < 9) ? 9'(9'h1 << i) : 9'h0;
            serr = 2'(i);
            ev = i[0];
            cyc(2);
            chk("event", cev, i[0]);
            cyc(1);
            chk("iommu_irq", irq[111:103], iirq);
            chk("serr", irq[207], |serr);
        end
        {iirq, serr, ev} = '0;
        $display("test irq done");
        for (i = 0; i < 10; i++) begin
            dsel = i[0];
            a = (i < 4) ? 32'h2F02_0040 + i : $random(seed);
            dt = $random(seed);
            xl = $random(seed);
            {g1, g0} = dsel ? 2'b10 : 2'b01;
            rid = dsel ? {b1, d1, 3'h0} : {b0, d0, 3'h0};
            cyc(1);
            chk("stream_id", sid, rid);
            chk("msi_id", mid, {1'b0, rid});
            chk("dma_valid", dmo.valid, 1'b1);
            chk("dma_addr", dmo.addr, xl);
            k = ((a & `PHB_MSI_WIN_MASK) == `PHB_MSI_WIN_BASE);
            chk("dma_data", dmo.data, k ? {16'h0, rid} : dt);
        end
        {g0, g1} = '0;
        cyc(1);
        chk("dma_idle", dmo.valid, 1'b0);
        $display("test dma done");
        for (i = 0; i < 4; i++) begin
            idi = $random(seed);
            c0i = $random(seed);
            c1i = $random(seed);
            {idld, ld} = 2'b11;
            cyc(1);
            {idld, ld} = '0;
            cyc(1);
            chk("self_id", ido, idi);
            chk("cfg", {c0o, c1o}, {c0i, c1i});
        end
        $display("test config done");
        print_verdict;
    end
endmodule
`default_nettype wire
